// ==== mab_pkg.sv ====
package mab_pkg;

  // Timing base
  localparam int CLK_MHZ     = 100;
  localparam int SIFS_US     = 16;
  localparam int SIFS_CYC    = SIFS_US * CLK_MHZ;
  localparam int SLOT_US_DEF = 9;
  localparam int AIFS_SLOTS  = 2;

  // Widths
  localparam int LEN_W   = 12;
  localparam int CW_W    = 10;
  localparam int TMR_W   = 16;
  localparam int LFSR_W  = 16;

  // Threshold limits and defaults
  localparam logic [LEN_W-1:0] RTS_MIN     = 12'h014;
  localparam logic [LEN_W-1:0] RTS_MAX     = 12'hFFC;
  localparam logic [LEN_W-1:0] RTS_DEF_BIG = 12'hFFC;
  localparam logic [LEN_W-1:0] RTS_DEF_SML = 12'h898;
  localparam logic [LEN_W-1:0] FRAME_MAX   = 12'hFFC;

  // Contention window ladder
  localparam logic [CW_W-1:0] CW_ZERO    = 10'h000;
  localparam logic [CW_W-1:0] CW_FLOOR   = 10'h007;
  localparam logic [CW_W-1:0] CW_MIN_DEF = 10'h00F;
  localparam logic [CW_W-1:0] CW_MAX_DEF = 10'h3FF;

  // Random source, nonzero seed required
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_IFS     = 3'b001,
    ST_BACKOFF = 3'b010,
    ST_WAIT    = 3'b011
  } mab_state_t;

  typedef struct packed {
    logic             valid;
    logic             urgent;
    logic [LEN_W-1:0] len;
  } mab_req_t;

  typedef struct packed {
    logic [LEN_W-1:0] rts_thr;
    logic [CW_W-1:0]  cw_min;
    logic [CW_W-1:0]  cw_max;
  } mab_cfg_t;

  // Snap any value onto the ladder: fill ones below the top bit, floor at 7 (a zero stays zero when allow_zero is set)
  function automatic logic [CW_W-1:0] cw_legal(input logic [CW_W-1:0] v,
                                                input logic allow_zero);
    logic [CW_W-1:0] r;
    r = v;
    for (int i = 0; i < CW_W; i++) begin
      r = r | (r >> 1);
    end
    if (r < CW_FLOOR) begin
      r = CW_FLOOR;
    end
    if (allow_zero && (v == CW_ZERO)) begin
      r = CW_ZERO;
    end
    return r;
  endfunction

endpackage

// ==== mab_lfsr.sv ====
module mab_lfsr
  import mab_pkg::*;
#(
  parameter int W = LFSR_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  output logic [W-1:0]      rnd
);

  typedef struct packed {
    logic [W-1:0] q;
  } mab_lfsr_st_t;

  mab_lfsr_st_t s_r;
  mab_lfsr_st_t s_nxt;

  // Galois shift, free running so draws depend on arrival time
  always_comb begin
    s_nxt   = s_r;
    s_nxt.q = (s_r.q >> 1) ^ (s_r.q[0] ? W'(LFSR_TAPS) : '0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.q <= W'(LFSR_SEED);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rnd = s_r.q;

endmodule // mab_lfsr

// ==== mab_cw_ladder.sv ====
module mab_cw_ladder
  import mab_pkg::*;
(
  input  wire logic [CW_W-1:0] cur,
  input  wire logic [CW_W-1:0] cap,
  output logic [CW_W-1:0]      nxt
);

  logic [CW_W-1:0] grow;

  // Next rung is 2C+1; a zero window climbs to the first rung
  always_comb begin
    grow = (cur < CW_FLOOR) ? CW_FLOOR : CW_W'({cur, 1'b1});
    nxt  = (grow > cap) ? cap : grow;
  end

endmodule // mab_cw_ladder

// ==== mab_medium_access.sv ====
module mab_medium_access
  import mab_pkg::*;
#(
  parameter int               SLOT_CYC = SLOT_US_DEF * CLK_MHZ,
  parameter logic [LEN_W-1:0] RTS_DEF  = RTS_DEF_BIG,
  parameter logic [LEN_W-1:0] MAX_LEN  = FRAME_MAX
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            cfg_load,
  input  wire mab_cfg_t        cfg,
  input  wire mab_req_t        tx_req,
  output logic                 tx_req_ready,
  input  wire logic            carrier_busy,
  input  wire logic            tx_done,
  input  wire logic            tx_collision,
  output logic                 tx_start,
  output logic                 tx_use_rts,
  output logic [CW_W-1:0]      cw_bound,
  output mab_state_t           access_state
);

  localparam int DIFS_CYC = SIFS_CYC + AIFS_SLOTS * SLOT_CYC;
  localparam logic [TMR_W-1:0] SIFS_LAST = TMR_W'(SIFS_CYC - 1);
  localparam logic [TMR_W-1:0] DIFS_LAST = TMR_W'(DIFS_CYC - 1);
  localparam logic [TMR_W-1:0] SLOT_LAST = TMR_W'(SLOT_CYC - 1);
  localparam logic [TMR_W-1:0] RUN_SAT   = '1;

  typedef struct packed {
    mab_state_t       state;
    logic             cs_meta;
    logic             cs_busy;
    logic [TMR_W-1:0] cnt;
    logic [CW_W-1:0]  slots;
    logic [CW_W-1:0]  cw;
    logic [LEN_W-1:0] thr;
    logic [CW_W-1:0]  cwmin;
    logic [CW_W-1:0]  cwmax;
    logic             urgent;
    logic             rts;
    logic             draw;
    logic             start;
    logic [TMR_W-1:0] idle_run;
  } mab_st_t;

  mab_st_t         s_r;
  mab_st_t         s_nxt;
  logic [LFSR_W-1:0] rnd;
  logic [CW_W-1:0] cw_up;
  logic [CW_W-1:0] pick;
  logic [TMR_W-1:0] ifs_last;
  logic            busy;
  logic            ifs_done;

  mab_lfsr #(
    .W (LFSR_W)
  ) i_mab_lfsr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .rnd     (rnd)
  );

  mab_cw_ladder i_mab_cw_ladder (
    .cur (s_r.cw),
    .cap (s_r.cwmax),
    .nxt (cw_up)
  );

  // Only the second sync stage is looked at
  assign busy     = s_r.cs_busy;
  assign ifs_last = s_r.urgent ? SIFS_LAST : DIFS_LAST;
  assign ifs_done = (s_r.state == ST_IFS) && !busy && (s_r.cnt == ifs_last);
  assign pick     = rnd[CW_W-1:0] & s_r.cw;

  // Next-state logic for the whole access engine
  always_comb begin
    s_nxt          = s_r;
    s_nxt.cs_meta  = carrier_busy;
    s_nxt.cs_busy  = s_r.cs_meta;
    s_nxt.start    = 1'b0;
    s_nxt.idle_run = busy ? '0 : ((s_r.idle_run == RUN_SAT) ? RUN_SAT : s_r.idle_run + 1'b1);

    // Config sanitised on entry so illegal values never reach the engine
    if (cfg_load) begin
      if (cfg.rts_thr < RTS_MIN) begin
        s_nxt.thr = RTS_MIN;
      end else if (cfg.rts_thr > RTS_MAX) begin
        s_nxt.thr = RTS_MAX;
      end else begin
        s_nxt.thr = cfg.rts_thr;
      end
      s_nxt.cwmin = cw_legal(cfg.cw_min, 1'b1);
      s_nxt.cwmax = cw_legal(cfg.cw_max, 1'b0);
    end

    case (s_r.state)
      ST_IDLE: begin
        if (tx_req.valid) begin
          s_nxt.urgent = tx_req.urgent;
          // RTS only for big data frames and only if the threshold is reachable
          s_nxt.rts    = !tx_req.urgent && (s_r.thr <= MAX_LEN)
                         && (tx_req.len >= s_r.thr);
          s_nxt.cnt    = '0;
          s_nxt.draw   = 1'b1;
          s_nxt.state  = ST_IFS;
        end
      end
      ST_IFS: begin
        if (busy) begin
          // Spacing restarts once the medium frees again
          s_nxt.cnt = '0;
        end else if (s_r.cnt == ifs_last) begin
          s_nxt.cnt = '0;
          if (s_r.urgent || (s_r.cwmin == CW_ZERO)) begin
            s_nxt.start = 1'b1;
            s_nxt.state = ST_WAIT;
          end else if (s_r.draw) begin
            s_nxt.draw  = 1'b0;
            s_nxt.slots = pick;
            if (pick == CW_ZERO) begin
              s_nxt.start = 1'b1;
              s_nxt.state = ST_WAIT;
            end else begin
              s_nxt.state = ST_BACKOFF;
            end
          end else if (s_r.slots == CW_ZERO) begin
            s_nxt.start = 1'b1;
            s_nxt.state = ST_WAIT;
          end else begin
            s_nxt.state = ST_BACKOFF;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ST_BACKOFF: begin
        if (busy) begin
          // Freeze the remaining slots; resume after a fresh DIFS
          s_nxt.cnt   = '0;
          s_nxt.state = ST_IFS;
        end else if (s_r.cnt == SLOT_LAST) begin
          s_nxt.cnt   = '0;
          s_nxt.slots = s_r.slots - 1'b1;
          if (s_r.slots == CW_W'(1)) begin
            s_nxt.start = 1'b1;
            s_nxt.state = ST_WAIT;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      ST_WAIT: begin
        if (tx_done) begin
          s_nxt.cw    = s_r.cwmin;
          s_nxt.state = ST_IDLE;
        end else if (tx_collision) begin
          s_nxt.cw    = cw_up;
          s_nxt.draw  = 1'b1;
          s_nxt.cnt   = '0;
          s_nxt.state = ST_IFS;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
  end

  // State register; reset holds the documented defaults
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.state    <= ST_IDLE;
      s_r.cs_meta  <= 1'b1;
      s_r.cs_busy  <= 1'b1;
      s_r.cnt      <= '0;
      s_r.slots    <= CW_ZERO;
      s_r.cw       <= CW_MIN_DEF;
      s_r.thr      <= RTS_DEF;
      s_r.cwmin    <= CW_MIN_DEF;
      s_r.cwmax    <= CW_MAX_DEF;
      s_r.urgent   <= 1'b0;
      s_r.rts      <= 1'b0;
      s_r.draw     <= 1'b0;
      s_r.start    <= 1'b0;
      s_r.idle_run <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign tx_req_ready = (s_r.state == ST_IDLE);
  assign tx_start     = s_r.start;
  assign tx_use_rts   = s_r.rts;
  assign cw_bound     = s_r.cw;
  assign access_state = s_r.state;

  // Checks
  property p_rts_short;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_IDLE && tx_req.valid && tx_req.len < s_r.thr) |=> !tx_use_rts;
  endproperty
  a_rts_short: assert property (p_rts_short) else $error("short frame got RTS");

  property p_rts_long;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_IDLE && tx_req.valid && !tx_req.urgent && tx_req.len >= s_r.thr
     && s_r.thr <= MAX_LEN) |=> tx_use_rts;
  endproperty
  a_rts_long: assert property (p_rts_long) else $error("long frame missed RTS");

  property p_thr_range;
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_load |=> (s_r.thr >= RTS_MIN && s_r.thr <= RTS_MAX);
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range");

  property p_no_rts_high;
    @(posedge sys_clk) disable iff (!rst_n)
    (tx_start && s_r.thr > MAX_LEN) |-> !tx_use_rts;
  endproperty
  a_no_rts_high: assert property (p_no_rts_high) else $error("RTS above frame max");

  property p_sifs_gap;
    @(posedge sys_clk) disable iff (!rst_n)
    (tx_start && s_r.urgent) |-> (s_r.idle_run >= TMR_W'(SIFS_CYC));
  endproperty
  a_sifs_gap: assert property (p_sifs_gap) else $error("urgent start before SIFS");

  property p_difs_gap;
    @(posedge sys_clk) disable iff (!rst_n)
    (tx_start && !s_r.urgent) |-> (s_r.idle_run >= TMR_W'(DIFS_CYC));
  endproperty
  a_difs_gap: assert property (p_difs_gap) else $error("start before DIFS");

  property p_busy_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_BACKOFF && busy) |=> (s_r.state == ST_IFS && $stable(s_r.slots));
  endproperty
  a_busy_freeze: assert property (p_busy_freeze) else $error("backoff ran while busy");

  // Any busy cycle inside the spacing throws away the idle time counted so far
  property p_ifs_restart;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_IFS && busy) |=> (s_r.state == ST_IFS && s_r.cnt == '0);
  endproperty
  a_ifs_restart: assert property (p_ifs_restart) else $error("spacing ran while busy");

  property p_draw_bound;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_BACKOFF) |-> (s_r.slots <= s_r.cw && s_r.slots != CW_ZERO);
  endproperty
  a_draw_bound: assert property (p_draw_bound) else $error("slot count above window");

  property p_ladder;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_WAIT && !tx_done && tx_collision && s_r.cw >= CW_FLOOR
     && {s_r.cw, 1'b1} <= {1'b0, s_r.cwmax})
    |=> (s_r.cw == CW_W'({$past(s_r.cw), 1'b1}));
  endproperty
  a_ladder: assert property (p_ladder) else $error("window did not climb");

  property p_cwmin_legal;
    @(posedge sys_clk) disable iff (!rst_n)
    ((s_r.cwmin & (s_r.cwmin + 1'b1)) == CW_ZERO)
    && (s_r.cwmin == CW_ZERO || s_r.cwmin >= CW_FLOOR);
  endproperty
  a_cwmin_legal: assert property (p_cwmin_legal) else $error("illegal minimum window");

  property p_no_backoff;
    @(posedge sys_clk) disable iff (!rst_n)
    (ifs_done && s_r.cwmin == CW_ZERO) |=> (tx_start && s_r.state == ST_WAIT);
  endproperty
  a_no_backoff: assert property (p_no_backoff) else $error("zero window still backed off");

  property p_cwmax_legal;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.cwmax >= CW_FLOOR) && ((s_r.cwmax & (s_r.cwmax + 1'b1)) == CW_ZERO);
  endproperty
  a_cwmax_legal: assert property (p_cwmax_legal) else $error("illegal maximum window");

  // A load in the same cycle may lower the cap, so that case is left out
  property p_cw_sat;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_WAIT && !tx_done && tx_collision && !cfg_load)
    |=> (s_r.cw <= s_r.cwmax);
  endproperty
  a_cw_sat: assert property (p_cw_sat) else $error("window above maximum");

  property p_success_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    (s_r.state == ST_WAIT && tx_done && !cfg_load) |=> (s_r.cw == s_r.cwmin);
  endproperty
  a_success_reset: assert property (p_success_reset) else $error("window not reset");

endmodule // mab_medium_access

// ==== mab_peer_model.sv ====
module mab_peer_model
  import mab_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       jam,
  input  wire logic [3:0] n_coll,
  input  wire logic [7:0] ans_dly,
  input  wire logic       tx_start,
  output logic            carrier_busy,
  output logic            tx_done,
  output logic            tx_collision
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] dly_r;
  logic [3:0] cnt_r;

  // Other stations occupy the air only when the bench asks
  assign carrier_busy = jam;

  // Answer each start after a delay; collide n_coll times, then succeed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_r        <= 8'h00;
      cnt_r        <= 4'h0;
      tx_done      <= 1'b0;
      tx_collision <= 1'b0;
    end else begin
      tx_done      <= 1'b0;
      tx_collision <= 1'b0;
      if (tx_start) begin
        dly_r <= ans_dly;
      end else if (dly_r != 8'h00) begin
        dly_r <= dly_r - 8'h01;
        if (dly_r == 8'h01 && cnt_r < n_coll) begin
          tx_collision <= 1'b1;
          cnt_r        <= cnt_r + 4'h1;
        end else if (dly_r == 8'h01) begin
          tx_done <= 1'b1;
          cnt_r   <= 4'h0;
        end
      end
    end
  end
endmodule // mab_peer_model

// ==== tb_mab_medium_access.sv ====
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module tb_mab_medium_access;
  import mab_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SLT = 4;
  localparam int U   = SIFS_CYC;
  localparam int D   = SIFS_CYC + AIFS_SLOTS * SLT;

  logic sys_clk, rst_n, cfg_load, tx_req_ready, carrier_busy, tx_done;
  logic tx_collision, tx_start, tx_use_rts, jam;
  logic [3:0] n_coll;
  logic [7:0] ans_dly;
  logic [CW_W-1:0] cw_bound;
  mab_cfg_t cfg;
  mab_req_t tx_req;
  mab_state_t access_state;
  int error_cnt = 0;
  int n_checks = 0;

  // Small frame limit so a threshold above it can be set
  mab_medium_access #(.SLOT_CYC(SLT), .RTS_DEF(RTS_DEF_SML), .MAX_LEN(12'h0900))
  i_mab_medium_access (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_load(cfg_load),
    .cfg(cfg), .tx_req(tx_req), .tx_req_ready(tx_req_ready),
    .carrier_busy(carrier_busy), .tx_done(tx_done), .tx_collision(tx_collision),
    .tx_start(tx_start), .tx_use_rts(tx_use_rts), .cw_bound(cw_bound),
    .access_state(access_state));

  mab_peer_model i_mab_peer_model (.sys_clk(sys_clk), .rst_n(rst_n), .jam(jam),
    .n_coll(n_coll), .ans_dly(ans_dly), .tx_start(tx_start),
    .carrier_busy(carrier_busy), .tx_done(tx_done), .tx_collision(tx_collision));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Count cycles until the start pulse, bounded so a hang cannot stall
  task automatic wait_start(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (tx_start !== 1'b1 && k < 20000);
  endtask

  task automatic cfg_set(input logic [LEN_W-1:0] t, input logic [CW_W-1:0] lo,
                         input logic [CW_W-1:0] hi);
    @(posedge sys_clk);
    cfg      <= '{t, lo, hi};
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
  endtask

  task automatic send(input logic u, input logic [LEN_W-1:0] l, output int k);
    @(posedge sys_clk);
    tx_req <= '{1'b1, u, l};
    @(posedge sys_clk);
    tx_req.valid <= 1'b0;
    wait_start(k);
  endtask

  // Whole frame: check RTS choice and start delay, then wait for idle
  task automatic frame(input logic u, input logic [LEN_W-1:0] l, input logic rts,
                       input int lo, input int hi);
    int k;
    int j;
    send(u, l, k);
    `CHK(tx_use_rts, rts)
    `CHK(k >= lo && k <= hi, 1'b1)
    for (j = 0; j < 200 && tx_req_ready !== 1'b1; j++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(access_state, ST_IDLE)
  endtask

  task automatic t_reset();
    `CHK(cw_bound, CW_MIN_DEF)
    `CHK({tx_req_ready, tx_start, access_state}, {2'b10, ST_IDLE})
    $display("t_reset done");
  endtask

  task automatic t_rts();
    frame(1'b1, 12'h0FA0, 1'b0, U, U);
    frame(1'b0, 12'h0897, 1'b0, D, D + 15 * SLT);
    frame(1'b0, 12'h0898, 1'b1, D, D + 15 * SLT);
    cfg_set(12'h0005, CW_ZERO, CW_MAX_DEF);
    frame(1'b1, 12'h0040, 1'b0, U, U);
    `CHK(cw_bound, CW_ZERO)
    frame(1'b0, 12'h0013, 1'b0, D, D);
    frame(1'b0, 12'h0014, 1'b1, D, D);
    cfg_set(12'h0FFF, CW_ZERO, CW_MAX_DEF);
    frame(1'b0, 12'h0900, 1'b0, D, D);
    $display("t_rts done");
  endtask

  // Carrier seen busy in mid spacing restarts the full spacing
  task automatic t_busy();
    fork
      frame(1'b1, 12'h0040, 1'b0, U + 812, U + 812);
      begin
        repeat (802) @(posedge sys_clk);
        jam <= 1'b1;
        repeat (10) @(posedge sys_clk);
        jam <= 1'b0;
      end
    join
    $display("t_busy done");
  endtask

  // Collisions climb the ladder and stop at the maximum 0x01F that the loaded 0x014 snaps to
  task automatic t_backoff();
    int k;
    int j;
    logic [CW_W-1:0] exp_c [3] = '{10'h00F, 10'h01F, 10'h01F};
    cfg_set(12'h0FFC, 10'h005, 10'h014);
    frame(1'b1, 12'h0040, 1'b0, U, U);
    `CHK(cw_bound, CW_FLOOR)
    n_coll  <= 4'h3;
    ans_dly <= 8'h28;
    send(1'b0, 12'h0020, k);
    `CHK(k >= D && k <= D + 7 * SLT, 1'b1)
    foreach (exp_c[i]) begin
      wait_start(k);
      `CHK(cw_bound, exp_c[i])
      `CHK(k >= D + 42 && k <= D + 42 + exp_c[i] * SLT, 1'b1)
    end
    // Peer answer takes 42 cycles; wait for idle so the next request is taken
    n_coll <= 4'h0;
    for (j = 0; j < 200 && tx_req_ready !== 1'b1; j++) begin
      @(posedge sys_clk);
      #1;
    end
    frame(1'b1, 12'h0040, 1'b0, U, U);
    `CHK(cw_bound, CW_FLOOR)
    $display("t_backoff done");
  endtask

  // Carrier seen mid backoff freezes the slots and re-waits a full DIFS
  task automatic t_defer();
    cfg_set(12'h0FFC, 10'h3FF, 10'h3FF);
    frame(1'b1, 12'h0040, 1'b0, U, U);
    `CHK(cw_bound, CW_MAX_DEF)
    fork
      frame(1'b0, 12'h0020, 1'b0, 2 * D + 17 + SLT, 2 * D + 17 + 1020 * SLT);
      begin
        repeat (D + 12) @(posedge sys_clk);
        jam <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK(access_state, ST_IFS)
        @(posedge sys_clk);
        jam <= 1'b0;
      end
    join
    $display("t_defer done");
  endtask

  // Main sequence
  initial begin
    rst_n    = 1'b0;
    cfg_load = 1'b0;
    cfg      = '0;
    tx_req   = '0;
    jam      = 1'b0;
    n_coll   = 4'h0;
    ans_dly  = 8'h03;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reset();
    t_rts();
    t_busy();
    t_backoff();
    t_defer();
    give_verdict();
  end

  // Watchdog well beyond the longest expected run
  initial begin
    #600000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_mab_medium_access
